// ===== logic/rcr_regs.sv
// Clock, reset and interrupt control register bank with APB slave
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ns
`include "rcr_map.svh"
module rcr_regs
   import rcr_pkg::*;
#(
   parameter int DEB_CYCLES = `RCR_DEB_CYCLES
) (
   input  wire logic                clk,
   input  wire logic                sys_rst,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [`RCR_AW-1:0]  paddr,
   input  wire logic [31:0]         pwdata,
   output logic                     pready,
   output logic                     pslverr,
   output logic [31:0]              prdata,
   input  wire logic                sw_reset_strb,
   input  wire logic                deep_sleep_strb,
   input  wire logic                idle_strb,
   input  wire logic                light_sleep_strb,
   input  wire logic                rx_cont_entry,
   input  wire logic                wake_on_rx,
   input  wire logic                wake_on_tx,
   input  wire logic                auto_ack_entry,
   input  wire logic                rx_timeout_evt,
   input  wire logic                rx_fifo_overwrite_evt,
   input  wire logic                rx_fifo_reset_strb,
   input  wire logic                rx_strb,
   input  wire logic                rx_fail_evt,
   input  wire logic                rx_crc_fail_evt,
   input  wire logic                crc_check_en,
   input  wire logic [7:0]          irq_event,
   output logic                     xtal_clk_gate_en,
   output logic                     divided_sys_clk_tick,
   output logic                     sys_clk_ready,
   output logic                     xtal_clk_ready,
   output logic                     core_logic_reset,
   output logic [1:0]               rx_detect_select,
   output logic                     rx_detect_sync,
   output logic                     irq_out
);
   // ************************************************************
   // State and submodules
   // ************************************************************
   rcr_main_t st_q;
   rcr_main_t st_d;
   logic      xrdy;
   logic      div_tick;
   logic      wr;
   logic      setup;
   logic      any_irq;
   logic      sleep_cmd;

   localparam rcr_main_t RST_VAL = '{
      power_on_flag:  1'b1,
      xen:    1'b1,
      div:    `RCR_DIV_RST,
      sen:    1'b0,
      crst:   1'b0,
      sck:    SCK_OFF,
      srdy:   1'b0,
      rx_timeout_flag:   1'b0,
      ovr:    1'b0,
      crcf:   1'b0,
      det:    `RCR_DET_RST,
      cpol:   1'b0,
      ipol:   1'b1,
      flags:  8'h00,
      ien:    8'h00,
      rdata:  32'h0000_0000,
      slverr: 1'b0,
      irq:    1'b0
   };

   assign sleep_cmd = deep_sleep_strb | idle_strb;

   rcr_debounce #(
      .DEB_CYCLES (DEB_CYCLES)
   ) u_deb (
      .clk     (clk),
      .sys_rst (sys_rst),
      .run     (st_q.xen && !st_q.crst),
      .clr     (sw_reset_strb || sleep_cmd),
      .ready   (xrdy)
   );

   rcr_clk_div u_div (
      .clk     (clk),
      .sys_rst (sys_rst),
      .en      (st_q.sen),
      .sel     (st_q.div),
      .tick    (div_tick)
   );

   // ************************************************************
   // Address decode and read mux
   // ************************************************************
   function automatic logic addr_hit(input logic [`RCR_AW-1:0] a, input logic [`RCR_AW-1:0] off);
      addr_hit = (a == off);
   endfunction

   function automatic logic mapped(input logic [`RCR_AW-1:0] a);
      mapped = addr_hit(a, `RCR_OFF_RCC) || addr_hit(a, `RCR_OFF_IRQC) ||
               addr_hit(a, `RCR_OFF_FLAG) || addr_hit(a, `RCR_OFF_IEN);
   endfunction

   function automatic logic [7:0] rcc_byte(input rcr_main_t s, input logic xr);
      logic [7:0] b;
      b = 8'h00;
      b[`RCR_B_POWER_ON_FLAG]               = s.power_on_flag;
      b[`RCR_B_SRDY]                = s.srdy;
      b[`RCR_B_XRDY]                = xr;
      b[`RCR_B_XEN]                 = s.xen;
      b[`RCR_B_DIV_HI:`RCR_B_DIV_LO] = s.div;
      b[`RCR_B_SEN]                 = s.sen;
      b[`RCR_B_CRST]                = s.crst;
      rcc_byte = b;
   endfunction

   function automatic logic [7:0] irqc_byte(input rcr_main_t s);
      logic [7:0] b;
      b = 8'h00;
      b[`RCR_B_RX_TIMEOUT_FLAG]                = s.rx_timeout_flag;
      b[`RCR_B_OVR]                 = s.ovr;
      b[`RCR_B_CRCF]                = s.crcf;
      b[`RCR_B_DET_HI:`RCR_B_DET_LO] = s.det;
      b[`RCR_B_CPOL]                = s.cpol;
      b[`RCR_B_IPOL]                = s.ipol;
      irqc_byte = b;
   endfunction

   assign setup = psel && !penable;
   assign wr    = psel && penable && pwrite && mapped(paddr);

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      st_d    = st_q;
      any_irq = |(st_q.flags & st_q.ien);

      // Read data captured in setup, shown in access phase
      if (setup) begin
         st_d.slverr = !mapped(paddr);
         st_d.rdata  = 32'h0000_0000;
         if (addr_hit(paddr, `RCR_OFF_RCC)) begin
            st_d.rdata[7:0] = rcc_byte(st_q, xrdy);
         end else if (addr_hit(paddr, `RCR_OFF_IRQC)) begin
            st_d.rdata[7:0] = irqc_byte(st_q);
         end else if (addr_hit(paddr, `RCR_OFF_FLAG)) begin
            st_d.rdata[7:0] = st_q.flags;
         end else if (addr_hit(paddr, `RCR_OFF_IEN)) begin
            st_d.rdata[7:0] = st_q.ien;
         end
      end

      // Software writes
      if (wr && addr_hit(paddr, `RCR_OFF_RCC)) begin
         st_d.power_on_flag = pwdata[`RCR_B_POWER_ON_FLAG];
         st_d.xen   = pwdata[`RCR_B_XEN];
         st_d.div   = pwdata[`RCR_B_DIV_HI:`RCR_B_DIV_LO];
         st_d.sen   = pwdata[`RCR_B_SEN];
         st_d.crst  = pwdata[`RCR_B_CRST];
      end
      if (wr && addr_hit(paddr, `RCR_OFF_IRQC)) begin
         st_d.crcf = pwdata[`RCR_B_CRCF];
         st_d.det  = pwdata[`RCR_B_DET_HI:`RCR_B_DET_LO];
         st_d.cpol = pwdata[`RCR_B_CPOL];
         st_d.ipol = pwdata[`RCR_B_IPOL];
      end
      if (wr && addr_hit(paddr, `RCR_OFF_FLAG)) begin
         for (int i = 0; i < 8; i++) begin
            if (pwdata[i] == st_q.cpol) begin
               st_d.flags[i] = 1'b0;
            end
         end
      end
      if (wr && addr_hit(paddr, `RCR_OFF_IEN)) begin
         st_d.ien = pwdata[7:0];
      end

      // Software reset strobe; power-on flag untouched
      if (sw_reset_strb) begin
         st_d.xen   = RST_VAL.xen;
         st_d.crst  = RST_VAL.crst;
         st_d.rx_timeout_flag  = RST_VAL.rx_timeout_flag;
         st_d.ovr   = RST_VAL.ovr;
         st_d.crcf  = RST_VAL.crcf;
         st_d.det   = RST_VAL.det;
         st_d.cpol  = RST_VAL.cpol;
         st_d.ipol  = RST_VAL.ipol;
         st_d.flags = RST_VAL.flags;
         st_d.ien   = RST_VAL.ien;
      end

      // Hardware flag clears, then sets win
      if (light_sleep_strb || rx_cont_entry || wake_on_rx || wake_on_tx || auto_ack_entry) begin
         st_d.rx_timeout_flag = 1'b0;
      end
      if (rx_timeout_evt) begin
         st_d.rx_timeout_flag = 1'b1;
      end
      if (rx_fifo_reset_strb || rx_strb) begin
         st_d.ovr = 1'b0;
      end
      if (rx_fifo_overwrite_evt) begin
         st_d.ovr = 1'b1;
      end
      if (rx_crc_fail_evt) begin
         st_d.crcf = 1'b1;
      end
      st_d.flags = st_d.flags | irq_event;
      if (rx_fail_evt || (rx_crc_fail_evt && crc_check_en) || rx_fifo_overwrite_evt) begin
         st_d.flags[`RCR_B_RXERR] = 1'b1;
      end

      // Divided clock ready sequencing
      case (st_q.sck)
         SCK_OFF: begin
            if (st_q.sen && xrdy) begin
               st_d.sck = SCK_WAIT;
            end
         end
         SCK_WAIT: begin
            if (div_tick) begin
               st_d.sck = SCK_ON;
            end
         end
         SCK_ON: begin
            st_d.sck = SCK_ON;
         end
         default: begin
            st_d.sck = SCK_OFF;
         end
      endcase
      if (!st_q.sen || !xrdy || sleep_cmd) begin
         st_d.sck = SCK_OFF;
      end
      st_d.srdy = (st_d.sck == SCK_ON);

      // Interrupt pin level
      st_d.irq = st_q.ipol ? any_irq : !any_irq;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_q <= RST_VAL;
      end else begin
         st_q <= st_d;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign pready               = 1'b1;
   assign pslverr              = psel && penable && st_q.slverr;
   assign prdata               = st_q.rdata;
   assign xtal_clk_gate_en     = st_q.xen;
   assign divided_sys_clk_tick = div_tick;
   assign sys_clk_ready        = st_q.srdy;
   assign xtal_clk_ready       = xrdy;
   assign core_logic_reset     = st_q.crst;
   assign rx_detect_select     = st_q.det;
   assign rx_detect_sync       = st_q.det[1];
   assign irq_out              = st_q.irq;

   // ************************************************************
   // Assertions
   // ************************************************************
   sequence s_rx_evt_clear;
      (light_sleep_strb || rx_cont_entry || wake_on_rx || wake_on_tx || auto_ack_entry) && !rx_timeout_evt;
   endsequence

   sequence s_flag0_clear;
      wr && addr_hit(paddr, `RCR_OFF_FLAG) && pwdata[0] == st_q.cpol && !irq_event[0] && !sw_reset_strb;
   endsequence

   AST_POWER_ON_FLAG_KEEP: assert property (@(posedge clk) disable iff (sys_rst)
      (sw_reset_strb && st_q.power_on_flag && !wr) |=> st_q.power_on_flag) else $error("power-on flag lost on soft reset");

   AST_SRDY_OFF: assert property (@(posedge clk) disable iff (sys_rst)
      (!st_q.sen || sleep_cmd) |=> !sys_clk_ready) else $error("sys clock ready stayed high");

   AST_XRDY_CLR: assert property (@(posedge clk) disable iff (sys_rst)
      (sw_reset_strb || sleep_cmd || !st_q.xen || st_q.crst) |=> !xtal_clk_ready) else $error("xtal ready not cleared");

   AST_XRDY_SLEEP: assert property (@(posedge clk) disable iff (sys_rst)
      deep_sleep_strb |=> !xtal_clk_ready [*2]) else $error("xtal ready too soon after deep sleep");

   AST_SRDY_ORDER: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(sys_clk_ready) |-> $past(xtal_clk_ready) && $past(st_q.sen, 2)) else $error("sys ready before enable");

   AST_RX_TIMEOUT_FLAG_CLR: assert property (@(posedge clk) disable iff (sys_rst)
      s_rx_evt_clear |=> !st_q.rx_timeout_flag) else $error("timeout flag not cleared");

   AST_OVR_SET: assert property (@(posedge clk) disable iff (sys_rst)
      rx_fifo_overwrite_evt |=> st_q.ovr) else $error("overrun flag not set");

   AST_FLAG_CLR: assert property (@(posedge clk) disable iff (sys_rst)
      s_flag0_clear |=> !st_q.flags[0]) else $error("flag not cleared by polarity write");

   AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (sys_rst)
      ##1 irq_out == ($past(st_q.ipol) ? $past(any_irq) : !$past(any_irq))) else $error("irq level wrong");

   AST_RXERR: assert property (@(posedge clk) disable iff (sys_rst)
      (rx_crc_fail_evt && crc_check_en) |=> st_q.flags[`RCR_B_RXERR]) else $error("rx error flag not set");
endmodule

// ===== logic/rcr_map.svh
// Register offsets, bit positions, reset values and counts of the clock/reset/irq register bank
`ifndef RCR_MAP_SVH
`define RCR_MAP_SVH

// ************************************************************
// Address map
// ************************************************************
`define RCR_AW          12
`define RCR_OFF_RCC     12'h000
`define RCR_OFF_IRQC    12'h004
`define RCR_OFF_FLAG    12'h008
`define RCR_OFF_IEN     12'h00C

// ************************************************************
// reset_clock_control fields
// ************************************************************
`define RCR_B_POWER_ON_FLAG     7
`define RCR_B_SRDY      6
`define RCR_B_XRDY      5
`define RCR_B_XEN       4
`define RCR_B_DIV_HI    3
`define RCR_B_DIV_LO    2
`define RCR_B_SEN       1
`define RCR_B_CRST      0

// ************************************************************
// interrupt_control_status fields
// ************************************************************
`define RCR_B_RX_TIMEOUT_FLAG      7
`define RCR_B_OVR       6
`define RCR_B_RSV       5
`define RCR_B_CRCF      4
`define RCR_B_DET_HI    3
`define RCR_B_DET_LO    2
`define RCR_B_CPOL      1
`define RCR_B_IPOL      0
`define RCR_B_RXERR     4

// ************************************************************
// Reset values and counts
// ************************************************************
`define RCR_IRQC_RST    8'h09
`define RCR_DET_RST     2'h2
`define RCR_DIV_RST     2'h0
`define RCR_DEB_CYCLES  16
`define RCR_DEB_W       16

`endif

// ===== logic/rcr_pkg.sv
// Types shared by the clock/reset/irq register bank
package rcr_pkg;
   typedef enum logic [1:0] {SCK_OFF, SCK_WAIT, SCK_ON} rcr_sck_t;

   typedef struct packed {
      logic        power_on_flag;
      logic        xen;
      logic [1:0]  div;
      logic        sen;
      logic        crst;
      rcr_sck_t    sck;
      logic        srdy;
      logic        rx_timeout_flag;
      logic        ovr;
      logic        crcf;
      logic [1:0]  det;
      logic        cpol;
      logic        ipol;
      logic [7:0]  flags;
      logic [7:0]  ien;
      logic [31:0] rdata;
      logic        slverr;
      logic        irq;
   } rcr_main_t;

   typedef struct packed {
      logic [15:0] cnt;
      logic        rdy;
   } rcr_deb_t;

   typedef struct packed {
      logic [2:0]  cnt;
      logic        tick;
   } rcr_div_t;
endpackage

// ===== logic/rcr_debounce.sv
// Crystal clock debounce counter with ready flag
`timescale 1ns/1ns
`include "rcr_map.svh"
module rcr_debounce
   import rcr_pkg::*;
#(
   parameter int DEB_CYCLES = `RCR_DEB_CYCLES
) (
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic run,
   input  wire logic clr,
   output logic      ready
);
   rcr_deb_t st_q;
   rcr_deb_t st_d;

   localparam logic [15:0] FULL = 16'(DEB_CYCLES);

   always_comb begin
      st_d = st_q;
      if (!run || clr) begin
         st_d.cnt = 16'h0000;
         st_d.rdy = 1'b0;
      end else if (st_q.cnt != FULL) begin
         st_d.cnt = st_q.cnt + 16'h0001;
      end else begin
         st_d.rdy = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign ready = st_q.rdy;

   AST_DEB_FULL: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(ready) |-> $past(st_q.cnt) == FULL) else $error("ready rose before full count");
endmodule

// ===== logic/rcr_clk_div.sv
// Divided system clock tick generator, divide by 1, 2, 4 or 8
`timescale 1ns/1ns
`include "rcr_map.svh"
module rcr_clk_div
   import rcr_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic       en,
   input  wire logic [1:0] sel,
   output logic            tick
);
   rcr_div_t st_q;
   rcr_div_t st_d;

   function automatic logic [2:0] div_mask(input logic [1:0] s);
      case (s)
         2'h0:    div_mask = 3'h0;
         2'h1:    div_mask = 3'h1;
         2'h2:    div_mask = 3'h3;
         default: div_mask = 3'h7;
      endcase
   endfunction

   always_comb begin
      st_d = st_q;
      if (!en) begin
         st_d.cnt  = 3'h0;
         st_d.tick = 1'b0;
      end else begin
         st_d.cnt  = st_q.cnt + 3'h1;
         st_d.tick = (st_q.cnt & div_mask(sel)) == div_mask(sel);
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign tick = st_q.tick;

   AST_DIV8_GAP: assert property (@(posedge clk) disable iff (sys_rst)
      (tick && en && sel == 2'h3 && $past(sel) == 2'h3) |=> !tick) else $error("divide by 8 ticked twice");
endmodule

// ===== test/tb_rcr_regs.sv
// Self-checking testbench of the clock/reset/irq register bank
`timescale 1ns/1ns
`include "rcr_map.svh"
module tb_rcr_regs;
   import rcr_pkg::*;
   // ************************************************************
   // Signals
   // ************************************************************
   localparam int DEB = 4;
   typedef struct {
      logic [11:0] a;
      logic [7:0]  d;
      logic [31:0] q;
      logic        e;
   } rcr_row_t;
   logic        clk;
   logic        sys_rst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic        pready;
   logic        pslverr;
   logic [31:0] prdata;
   logic [23:0] ev;
   logic        divided_sys_clk_tick;
   logic        sys_clk_ready;
   logic        xtal_clk_ready;
   logic        xtal_clk_gate_en;
   logic        core_logic_reset;
   logic [1:0]  rx_detect_select;
   logic        rx_detect_sync;
   logic        irq_out;
   int          mismatches;
   int          n_checks;
   int          n;
   logic [31:0] r;
   logic        e;
   rcr_row_t    rows [10];

   rcr_regs #(.DEB_CYCLES(DEB)) dut_u (
      .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
      .sw_reset_strb(ev[0]), .deep_sleep_strb(ev[1]), .idle_strb(ev[2]), .light_sleep_strb(ev[3]),
      .rx_cont_entry(ev[4]), .wake_on_rx(ev[5]), .wake_on_tx(ev[6]), .auto_ack_entry(ev[7]),
      .rx_timeout_evt(ev[8]), .rx_fifo_overwrite_evt(ev[9]), .rx_fifo_reset_strb(ev[10]),
      .rx_strb(ev[11]), .rx_fail_evt(ev[12]), .rx_crc_fail_evt(ev[13]), .crc_check_en(ev[14]),
      .irq_event(ev[23:16]), .xtal_clk_gate_en(xtal_clk_gate_en),
      .divided_sys_clk_tick(divided_sys_clk_tick), .sys_clk_ready(sys_clk_ready),
      .xtal_clk_ready(xtal_clk_ready), .core_logic_reset(core_logic_reset),
      .rx_detect_select(rx_detect_select), .rx_detect_sync(rx_detect_sync), .irq_out(irq_out)
   );

   // ************************************************************
   // Tasks
   // ************************************************************
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic conclude();
      if (mismatches == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (!(pready === 1'b1) && k < 50);
      if (pready !== 1'b1) mismatches++;
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [7:0] q, input string nm);
      apb(a, 1'b0, 8'h00);
      chk(nm, r, {24'h000000, q});
   endtask

   task automatic pulse(input int i);
      @(posedge clk);
      ev[i] <= 1'b1;
      @(posedge clk);
      ev[i] <= 1'b0;
   endtask

   task automatic wait_x(input logic v);
      int k;
      k = 0;
      while (xtal_clk_ready !== v && k < 60) begin
         @(posedge clk);
         k++;
      end
   endtask

   // ************************************************************
   // Clock, reset, watchdog
   // ************************************************************
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      conclude();
   end

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      sys_rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      ev = 24'h000000;
      mismatches = 0;
      n_checks = 0;
      rows = '{'{12'h000, 8'h0C, 32'h0000000C, 1'b0}, '{12'h000, 8'h03, 32'h00000003, 1'b0},
               '{12'h000, 8'h10, 32'h00000010, 1'b0}, '{12'h004, 8'hFF, 32'h0000001F, 1'b0},
               '{12'h004, 8'h00, 32'h00000000, 1'b0}, '{12'h004, 8'h09, 32'h00000009, 1'b0},
               '{12'h00C, 8'hA5, 32'h000000A5, 1'b0}, '{12'h00C, 8'h00, 32'h00000000, 1'b0},
               '{12'h010, 8'h5A, 32'h00000000, 1'b1}, '{12'hFFC, 8'h5A, 32'h00000000, 1'b1}};
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      // Table of write then read back
      foreach (rows[i]) begin
         apb(rows[i].a, 1'b1, rows[i].d);
         apb(rows[i].a, 1'b0, 8'h00);
         chk("row rdata", r, rows[i].q);
         chk("row slverr", {31'h0, e}, {31'h0, rows[i].e});
      end
      // Mid-run power-on reset
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      rd(12'h000, 8'h90, "rcc reset");
      rd(12'h004, 8'h09, "irqc reset");
      chk("det sel", {30'h0, rx_detect_select}, 32'h00000002);
      chk("irq idle", {31'h0, irq_out}, 32'h00000000);
      chk("gate", {31'h0, xtal_clk_gate_en}, 32'h00000001);
      chk("sys rdy off", {31'h0, sys_clk_ready}, 32'h00000000);
      wait_x(1'b1);
      rd(12'h000, 8'hB0, "xtal rdy");
      // Divider codes
      for (int c = 0; c < 4; c++) begin
         apb(12'h000, 1'b1, 8'h12 | 8'(c << 2));
         repeat (8) @(posedge clk);
         n = 0;
         repeat (16) begin
            @(posedge clk);
            if (divided_sys_clk_tick === 1'b1) n++;
         end
         chk("ticks", n, 16 >> c);
         chk("sys rdy", {31'h0, sys_clk_ready}, 32'h00000001);
         chk("gate div", {31'h0, xtal_clk_gate_en}, 32'h00000001);
      end
      // Software reset, deep sleep and idle strobes
      for (int i = 0; i < 3; i++) begin
         pulse(i);
         @(posedge clk);
         chk("xrdy strobe", {31'h0, xtal_clk_ready}, 32'h00000000);
         if (i > 0) chk("srdy strobe", {31'h0, sys_clk_ready}, 32'h00000000);
         wait_x(1'b1);
         chk("xrdy back", {31'h0, xtal_clk_ready}, 32'h00000001);
      end
      // Core reset and divided clock disable
      apb(12'h000, 1'b1, 8'h13);
      repeat (2) @(posedge clk);
      chk("core rst", {31'h0, core_logic_reset}, 32'h00000001);
      chk("xrdy crst", {31'h0, xtal_clk_ready}, 32'h00000000);
      apb(12'h000, 1'b1, 8'h10);
      wait_x(1'b1);
      chk("srdy off", {31'h0, sys_clk_ready}, 32'h00000000);
      chk("core run", {31'h0, core_logic_reset}, 32'h00000000);
      apb(12'h000, 1'b1, 8'h00);
      repeat (2) @(posedge clk);
      chk("gate off", {31'h0, xtal_clk_gate_en}, 32'h00000000);
      // Soft reset keeps power-on flag
      apb(12'h000, 1'b1, 8'h81);
      apb(12'h004, 1'b1, 8'h00);
      pulse(0);
      rd(12'h000, 8'h90, "rcc soft");
      rd(12'h004, 8'h09, "irqc soft");
      apb(12'h000, 1'b1, 8'h10);
      pulse(0);
      rd(12'h000, 8'h10, "power_on_flag soft0");
      // Detect select codes
      for (int c = 0; c < 4; c++) begin
         apb(12'h004, 1'b1, 8'h01 | 8'(c << 2));
         @(posedge clk);
         chk("det", {29'h0, rx_detect_sync, rx_detect_select}, {29'h0, 1'(c >> 1), 2'(c)});
      end
      apb(12'h004, 1'b1, 8'h09);
      // Timeout flag clear sources
      for (int i = 3; i < 8; i++) begin
         pulse(8);
         rd(12'h004, 8'h89, "rx_timeout_flag set");
         pulse(i);
         rd(12'h004, 8'h09, "rx_timeout_flag clr");
      end
      // Overrun flag clear sources
      for (int i = 10; i < 12; i++) begin
         pulse(9);
         rd(12'h004, 8'h49, "ovr set");
         rd(12'h008, 8'h10, "rxerr ovr");
         pulse(i);
         rd(12'h004, 8'h09, "ovr clr");
      end
      ev[14] <= 1'b1;
      pulse(13);
      rd(12'h004, 8'h19, "crc flag");
      // Interrupt output and flag clearing
      apb(12'h00C, 1'b1, 8'h10);
      repeat (2) @(posedge clk);
      chk("irq high", {31'h0, irq_out}, 32'h00000001);
      apb(12'h004, 1'b1, 8'h08);
      repeat (2) @(posedge clk);
      chk("irq low", {31'h0, irq_out}, 32'h00000000);
      apb(12'h008, 1'b1, 8'h10);
      rd(12'h008, 8'h10, "keep0");
      apb(12'h008, 1'b1, 8'h00);
      rd(12'h008, 8'h00, "clr0");
      repeat (2) @(posedge clk);
      chk("irq rel", {31'h0, irq_out}, 32'h00000001);
      apb(12'h004, 1'b1, 8'h0A);
      pulse(16);
      rd(12'h008, 8'h01, "evt0");
      apb(12'h008, 1'b1, 8'h00);
      rd(12'h008, 8'h01, "keep1");
      apb(12'h008, 1'b1, 8'h01);
      rd(12'h008, 8'h00, "clr1");
      pulse(12);
      rd(12'h008, 8'h10, "rxfail");
      conclude();
   end
endmodule
